// ===== core/vlhi_pkg.sv
// Package: constants and types for the link host interface block
package vlhi_pkg;

	// ------------------------------------------------------------
	// Register map (word index on the plain register port)
	// ------------------------------------------------------------
	localparam int unsigned  ADDR_W        = 3;
	localparam logic [2:0]   OFS_VECTOR    = 3'h0;
	localparam logic [2:0]   OFS_DATA      = 3'h1;
	localparam logic [2:0]   OFS_DELAY_CFG = 3'h2;
	localparam logic [2:0]   OFS_PORT_CTL  = 3'h3;
	localparam logic [2:0]   OFS_PORT_DATA = 3'h4;
	localparam logic [2:0]   OFS_PORT_DIR  = 3'h5;
	localparam logic [2:0]   OFS_CTL_TWO   = 3'h6;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int unsigned  DCF_ONCHIP    = 7;   // transceiver select
	localparam int unsigned  DCF_RX_POLARITY_SELECT     = 6;   // receive polarity
	localparam int unsigned  PCT_ENABLE    = 0;   // link function enable
	localparam int unsigned  PCT_PULLUP    = 1;   // port pull-ups
	localparam int unsigned  PCT_REDUCED   = 2;   // reduced drive
	localparam int unsigned  CT2_DIGITAL_LOOPBACK     = 0;   // digital loopback
	localparam int unsigned  CT2_ANALOG_LOOPBACK     = 1;   // analog loopback
	localparam int unsigned  CT2_TX_END_OF_DATA_REQUEST      = 2;   // end-of-data request
	localparam int unsigned  PIN_RX        = 0;   // receive pin in port
	localparam int unsigned  PIN_TX        = 1;   // transmit pin in port

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0]   RST_DELAY_CFG = 8'h00;
	localparam logic [7:0]   RST_PORT_CTL  = 8'h00;
	localparam logic [7:0]   RST_CTL_TWO   = 8'h00;
	localparam logic [6:0]   RST_PORT      = 7'h00;

	// ------------------------------------------------------------
	// Interrupt source codes, priority equals code
	// ------------------------------------------------------------
	localparam logic [3:0]   SRC_NONE      = 4'h0;
	localparam logic [3:0]   SRC_EOF       = 4'h1;
	localparam logic [3:0]   SRC_RX_IFR    = 4'h2;
	localparam logic [3:0]   SRC_RX_FULL   = 4'h3;
	localparam logic [3:0]   SRC_TX_EMPTY  = 4'h4;
	localparam logic [3:0]   SRC_ARB_LOSS  = 4'h5;
	localparam logic [3:0]   SRC_CRC       = 4'h6;
	localparam logic [3:0]   SRC_INVALID   = 4'h7;
	localparam logic [3:0]   SRC_WAKEUP    = 4'h8;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned  CLK_PERIOD_NS = 10;
	localparam int unsigned  US_NS         = 1000;
	localparam int unsigned  CYC_PER_US    = US_NS / CLK_PERIOD_NS;
	localparam int unsigned  DLY_BASE_US   = 9;   // delay at offset zero
	localparam int unsigned  DLY_STEP_US   = 1;   // delay per offset step
	localparam int unsigned  TAIL_BITS     = 2;   // logic-one bits after underrun

	// Events from the symbol layer
	typedef struct packed {
		logic       byte_valid;
		logic       byte_ifr;
		logic [7:0] byte_data;
		logic       eof;
		logic       arb_loss;
		logic       crc_err;
		logic       sym_invalid;
		logic       wakeup;
	} vlhi_evt_t;

	// Transmitter states
	typedef enum logic [1:0] {
		TX_IDLE  = 2'b00,
		TX_SHIFT = 2'b01,
		TX_TAIL  = 2'b10
	} vlhi_tx_st_t;

endpackage

// ===== core/vlhi_core.sv
// Module: register side, data double buffer and port pins of the link controller
`timescale 1ns/1ps

// Function
// - Vector byte is four times the pending source code, zero when idle.
// - Vector shows highest pending source; lower one appears once cleared.
// - Vector read clears reported source except data-servicing sources.
// - Receive sources clear after vector read then data byte read.
// - Transmit empty clears by vector read then data write, or end-of-data.
// - After invalid symbol cleared, no receive or transmit until end-of-frame.
// - Either loopback bit disconnects bus; no bus-derived conditions raised.
// - Finished shift register loads byte waiting in transmit shadow.
// - Transmit empty set once first bit shifted; shadow then accepts byte.
// - Received byte copied to receive shadow, sets full, overwritten by next.
// - Missing byte flags underrun; stop after byte plus two one bits.
// - Outside loopback, underrun truncation reported as invalid symbol condition.
// - Delay register readable always; one write normally, unlimited in special.
// - Transceiver select one means on-chip; software keeps it zero.
// - Receive polarity zero inverts receive pin, one passes it through.
// - Delay offset selects round trip 9 to 24 microseconds, 1 per step.
// - Link enable gives pins to controller; zero makes them general I/O.
// - Pull-up bit connects internal pull-ups when one.
// - Drive bit selects reduced drive strength when one.
// - Port data read gives pin level for inputs, latch for outputs.
// - Port writes skip link-driven pins; reset leaves pins as inputs.
// - Direction bit one makes pin output, zero input.
module vlhi_core
	import vlhi_pkg::*;
#(
	parameter int unsigned BIT_CYCLES = 64,  // clocks per transmitted bit
	parameter int unsigned PORT_W     = 7
) (
	input  wire logic              i_clock,
	input  wire logic              i_resetn,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [7:0]        i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic      [7:0]        o_rdata,
	input  wire logic              i_special_mode,
	input  wire vlhi_evt_t         i_evt,
	input  wire logic [PORT_W-1:0] i_pin_in,
	output logic      [PORT_W-1:0] o_pin_out,
	output logic      [PORT_W-1:0] o_pin_oe,
	output logic                   o_pullup_en,
	output logic                   o_reduced_drive,
	output logic                   o_rx_level,
	output logic      [11:0]       o_delay_cycles,
	output logic                   o_onchip_sel
);

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [8:1]        pend_ff,       nxt_pend;
	logic [7:0]        rdata_ff;
	logic [7:0]        dcfg_ff;
	logic              dcfg_lock_ff;
	logic [7:0]        pctl_ff;
	logic [7:0]        ctl2_ff;
	logic [PORT_W-1:0] pdata_ff;
	logic [PORT_W-1:0] pdir_ff;
	logic [PORT_W-1:0] pin_out_ff;
	logic [PORT_W-1:0] pin_oe_ff;
	logic              rx_level_ff;
	logic [11:0]       dly_ff;
	logic [7:0]        rx_shadow_ff;
	logic [7:0]        tx_shadow_ff;
	logic              tx_full_ff;
	logic [7:0]        tx_shift_ff;
	logic [2:0]        bit_cnt_ff;
	logic [15:0]       tick_cnt_ff;
	logic              tail_cnt_ff;
	logic              rx_arm_ff;     // vector read reported a receive source
	logic [3:0]        rx_arm_src_ff;
	logic              tx_arm_ff;     // vector read reported transmit empty
	logic              hush_ff;       // waiting for end-of-frame
	vlhi_tx_st_t       tx_st_ff,      nxt_tx_st;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	wire wr_data   = i_wr && (i_addr == OFS_DATA);
	wire wr_dcfg   = i_wr && (i_addr == OFS_DELAY_CFG);
	wire wr_pctl   = i_wr && (i_addr == OFS_PORT_CTL);
	wire wr_pdata  = i_wr && (i_addr == OFS_PORT_DATA);
	wire wr_pdir   = i_wr && (i_addr == OFS_PORT_DIR);
	wire wr_ctl2   = i_wr && (i_addr == OFS_CTL_TWO);
	wire rd_vec    = i_rd && (i_addr == OFS_VECTOR);
	wire rd_data   = i_rd && (i_addr == OFS_DATA);
	wire link_on   = pctl_ff[PCT_ENABLE];
	wire loop_on   = ctl2_ff[CT2_DIGITAL_LOOPBACK] | ctl2_ff[CT2_ANALOG_LOOPBACK];
	wire bus_live  = link_on && !loop_on;
	wire tx_end_of_data_request_set  = wr_ctl2 && i_wdata[CT2_TX_END_OF_DATA_REQUEST];

	wire [3:0] src_code = pend_ff[8] ? SRC_WAKEUP   :
	                      pend_ff[7] ? SRC_INVALID  :
	                      pend_ff[6] ? SRC_CRC      :
	                      pend_ff[5] ? SRC_ARB_LOSS :
	                      pend_ff[4] ? SRC_TX_EMPTY :
	                      pend_ff[3] ? SRC_RX_FULL  :
	                      pend_ff[2] ? SRC_RX_IFR   :
	                      pend_ff[1] ? SRC_EOF      : SRC_NONE;
	wire [7:0] vec_byte = {2'b00, src_code, 2'b00};
	wire       src_data = (src_code == SRC_RX_IFR) || (src_code == SRC_RX_FULL) ||
	                      (src_code == SRC_TX_EMPTY);

	// ------------------------------------------------------------
	// Transmitter timing
	// ------------------------------------------------------------
	wire bit_tick  = (tick_cnt_ff == 16'(BIT_CYCLES - 1));
	wire byte_end  = (tx_st_ff == TX_SHIFT) && bit_tick && (bit_cnt_ff == 3'h7);
	wire first_bit = (tx_st_ff == TX_SHIFT) && bit_tick && (bit_cnt_ff == 3'h0);
	wire tx_start  = (tx_st_ff == TX_IDLE) && tx_full_ff && link_on && !hush_ff;
	wire underrun  = byte_end && !tx_full_ff && !ctl2_ff[CT2_TX_END_OF_DATA_REQUEST];
	wire tx_reload = byte_end && tx_full_ff;

	// Transmitter next state
	always_comb begin
		nxt_tx_st = tx_st_ff;
		case (tx_st_ff)
			TX_IDLE: begin
				if (tx_start) begin
					nxt_tx_st = TX_SHIFT;
				end
			end
			TX_SHIFT: begin
				if (!link_on) begin
					nxt_tx_st = TX_IDLE;
				end else if (underrun) begin
					nxt_tx_st = TX_TAIL;
				end else if (byte_end && !tx_full_ff) begin
					nxt_tx_st = TX_IDLE;
				end
			end
			TX_TAIL: begin
				if (!link_on || (bit_tick && tail_cnt_ff)) begin
					nxt_tx_st = TX_IDLE;
				end
			end
			default: begin
				nxt_tx_st = TX_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Pending sources: set wins over clear
	// ------------------------------------------------------------
	logic [8:1] pend_set;
	logic [8:1] pend_clr;
	always_comb begin
		pend_set = '0;
		pend_clr = '0;
		pend_set[1] = bus_live && i_evt.eof;
		// no reception while waiting for end-of-frame
		pend_set[2] = bus_live && !hush_ff && i_evt.byte_valid && i_evt.byte_ifr;
		pend_set[3] = bus_live && !hush_ff && i_evt.byte_valid && !i_evt.byte_ifr;
		pend_set[4] = first_bit;
		pend_set[5] = bus_live && i_evt.arb_loss;
		pend_set[6] = bus_live && i_evt.crc_err;
		// truncated frame seen as invalid symbol
		pend_set[7] = (bus_live && i_evt.sym_invalid) || (bus_live && underrun);
		pend_set[8] = bus_live && i_evt.wakeup;
		if (rd_vec && (src_code != SRC_NONE) && !src_data) begin
			pend_clr[src_code] = 1'b1;
		end
		if (rd_data && rx_arm_ff) begin
			pend_clr[rx_arm_src_ff] = 1'b1;
		end
		// data write after vector read, or end-of-data
		if ((wr_data && tx_arm_ff) || tx_end_of_data_request_set) begin
			pend_clr[4] = 1'b1;
		end
		nxt_pend = (pend_ff & ~pend_clr) | pend_set;
	end

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	// inputs show pin, outputs show latch
	wire [PORT_W-1:0] pdata_rd = (pdir_ff & pdata_ff) | (~pdir_ff & i_pin_in);
	wire [7:0] rd_mux = (i_addr == OFS_VECTOR)    ? vec_byte :
	                    (i_addr == OFS_DATA)      ? rx_shadow_ff :
	                    (i_addr == OFS_DELAY_CFG) ? dcfg_ff :
	                    (i_addr == OFS_PORT_CTL)  ? pctl_ff :
	                    (i_addr == OFS_PORT_DATA) ? 8'(pdata_rd) :
	                    (i_addr == OFS_PORT_DIR)  ? 8'(pdir_ff) :
	                    (i_addr == OFS_CTL_TWO)   ? ctl2_ff : 8'h00;

	// ------------------------------------------------------------
	// Pin mapping
	// ------------------------------------------------------------
	// link takes receive and transmit pins
	wire [PORT_W-1:0] link_mask = link_on ? PORT_W'(2'b11) : '0;
	wire              tx_level  = (tx_st_ff == TX_SHIFT) ? tx_shift_ff[7] : (tx_st_ff == TX_TAIL);
	wire [PORT_W-1:0] gp_oe     = pdir_ff & ~link_mask;
	wire [PORT_W-1:0] nxt_oe    = gp_oe | (link_on ? PORT_W'(1) << PIN_TX : '0);
	wire [PORT_W-1:0] nxt_out   = (pdata_ff & gp_oe) | (link_on ? PORT_W'(tx_level) << PIN_TX : '0);
	wire              rx_true   = i_pin_in[PIN_RX] ^ ~dcfg_ff[DCF_RX_POLARITY_SELECT];
	// nine microseconds plus one per step
	wire [11:0]       nxt_dly   = 12'((DLY_BASE_US + DLY_STEP_US * dcfg_ff[3:0]) * CYC_PER_US);

	// ------------------------------------------------------------
	// Sequential: registers and flags
	// ------------------------------------------------------------
	// Software registers
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			dcfg_ff      <= RST_DELAY_CFG;
			dcfg_lock_ff <= 1'b0;
			pctl_ff      <= RST_PORT_CTL;
			pdata_ff     <= RST_PORT;
			pdir_ff      <= RST_PORT;
			rdata_ff     <= 8'h00;
		end else begin
			rdata_ff <= i_rd ? rd_mux : 8'h00;
			if (wr_dcfg && (!dcfg_lock_ff || i_special_mode)) begin
				dcfg_ff      <= i_wdata;
				dcfg_lock_ff <= !i_special_mode;
			end
			if (wr_pctl) begin
				pctl_ff <= {5'h00, i_wdata[2:0]};
			end
			// latch only, link pins ignore it
			if (wr_pdata) begin
				pdata_ff <= i_wdata[PORT_W-1:0];
			end
			if (wr_pdir) begin
				pdir_ff <= i_wdata[PORT_W-1:0];
			end
		end
	end

	// Control two, end-of-data held until transmitter idles
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			ctl2_ff <= RST_CTL_TWO;
		end else if (wr_ctl2) begin
			ctl2_ff <= {5'h00, i_wdata[2] | ctl2_ff[CT2_TX_END_OF_DATA_REQUEST], i_wdata[1:0]};
		end else if (byte_end && !tx_full_ff) begin
			ctl2_ff[CT2_TX_END_OF_DATA_REQUEST] <= 1'b0;
		end
	end

	// Flags and service arming
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			pend_ff       <= '0;
			rx_arm_ff     <= 1'b0;
			rx_arm_src_ff <= SRC_NONE;
			tx_arm_ff     <= 1'b0;
			hush_ff       <= 1'b0;
		end else begin
			pend_ff <= nxt_pend;
			if (rd_vec) begin
				rx_arm_ff     <= (src_code == SRC_RX_IFR) || (src_code == SRC_RX_FULL);
				rx_arm_src_ff <= src_code;
				tx_arm_ff     <= (src_code == SRC_TX_EMPTY);
			end else begin
				rx_arm_ff <= rx_arm_ff && !rd_data;
				tx_arm_ff <= tx_arm_ff && !wr_data;
			end
			// quiet from invalid clear until end-of-frame
			if (pend_clr[7]) begin
				hush_ff <= 1'b1;
			end else if (bus_live && i_evt.eof) begin
				hush_ff <= 1'b0;
			end
		end
	end

	// Receive shadow
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			rx_shadow_ff <= 8'h00;
		end else if (bus_live && !hush_ff && i_evt.byte_valid) begin
			rx_shadow_ff <= i_evt.byte_data;
		end
	end

	// Transmit shadow and shifter
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			tx_shadow_ff <= 8'h00;
			tx_full_ff   <= 1'b0;
			tx_shift_ff  <= 8'h00;
			bit_cnt_ff   <= 3'h0;
			tick_cnt_ff  <= 16'h0000;
			tail_cnt_ff  <= 1'b0;
			tx_st_ff     <= TX_IDLE;
		end else begin
			tx_st_ff    <= nxt_tx_st;
			tick_cnt_ff <= (tx_st_ff == TX_IDLE || bit_tick) ? 16'h0000 : tick_cnt_ff + 16'h0001;
			if (wr_data) begin
				tx_shadow_ff <= i_wdata;
				tx_full_ff   <= 1'b1;
			end else if (tx_start || tx_reload) begin
				tx_full_ff <= 1'b0;
			end
			if (tx_start || tx_reload) begin
				tx_shift_ff <= tx_shadow_ff;
				bit_cnt_ff  <= 3'h0;
			end else if (tx_st_ff == TX_SHIFT && bit_tick) begin
				tx_shift_ff <= {tx_shift_ff[6:0], 1'b0};
				bit_cnt_ff  <= bit_cnt_ff + 3'h1;
			end
			if (underrun) begin
				tail_cnt_ff <= 1'b0;
			end else if (tx_st_ff == TX_TAIL && bit_tick) begin
				tail_cnt_ff <= 1'b1;
			end
		end
	end

	// Pin and configuration outputs
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			pin_out_ff  <= RST_PORT;
			pin_oe_ff   <= RST_PORT;
			rx_level_ff <= 1'b0;
			dly_ff      <= 12'h000;
		end else begin
			pin_out_ff  <= nxt_out;
			pin_oe_ff   <= nxt_oe;
			rx_level_ff <= bus_live && rx_true;
			dly_ff      <= nxt_dly;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign o_rdata         = rdata_ff;
	assign o_pin_out       = pin_out_ff;
	assign o_pin_oe        = pin_oe_ff;
	assign o_pullup_en     = pctl_ff[PCT_PULLUP];
	assign o_reduced_drive = pctl_ff[PCT_REDUCED];
	assign o_rx_level      = rx_level_ff;
	assign o_delay_cycles  = dly_ff;
	// select bit passed out, on-chip unused here
	assign o_onchip_sel    = dcfg_ff[DCF_ONCHIP];

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_resetn);

	sequence s_vec_rx;
		rd_vec && (src_code == SRC_RX_FULL) && !(bus_live && i_evt.byte_valid);
	endsequence
	sequence s_data_rd;
		rd_data && !rd_vec && !(bus_live && !hush_ff && i_evt.byte_valid && !i_evt.byte_ifr);
	endsequence

	a_vec_scaled: assert property (i_rd && i_addr == OFS_VECTOR |=> o_rdata[1:0] == 2'b00 && o_rdata[7:6] == 2'b00)
		else $error("vector byte not a multiple of four");
	a_vec_top: assert property (pend_ff[8] && i_rd && i_addr == OFS_VECTOR |=> o_rdata == 8'h20)
		else $error("wakeup not reported first");
	a_arb_clear: assert property (rd_vec && src_code == SRC_ARB_LOSS && !(bus_live && i_evt.arb_loss)
		|=> !pend_ff[5])
		else $error("arbitration loss not cleared by vector read");
	a_rx_keep: assert property (rd_vec && src_code == SRC_RX_FULL |=> pend_ff[3])
		else $error("receive full cleared by vector read alone");
	a_rx_clear: assert property (s_vec_rx ##1 (!rd_vec && !rd_data)[*1] ##1 s_data_rd |=> !pend_ff[3])
		else $error("receive full not cleared by data read");
	a_tx_end_of_data_request_clear: assert property (tx_end_of_data_request_set && !first_bit |=> !pend_ff[4])
		else $error("end-of-data did not clear transmit empty");
	a_hush_rx: assert property (hush_ff && !i_evt.eof |=> $stable(rx_shadow_ff))
		else $error("byte accepted while waiting for end-of-frame");
	a_loop_quiet: assert property (loop_on && pend_ff == '0 && !(tx_st_ff == TX_SHIFT) |=> pend_ff == '0)
		else $error("condition raised while disconnected");
	a_first_bit: assert property (first_bit |=> pend_ff[4] && bit_cnt_ff == 3'h1)
		else $error("transmit empty not set after first bit");
	a_reload: assert property (tx_reload && !wr_data |=> !tx_full_ff && tx_st_ff == TX_SHIFT
		&& tx_shift_ff == $past(tx_shadow_ff))
		else $error("shadow byte not moved to shifter");
	a_tail_one: assert property (underrun && link_on |=> (tx_st_ff == TX_TAIL) && (pend_ff[7] || !$past(bus_live)))
		else $error("underrun did not enter trailing ones");
	a_dcfg_once: assert property (dcfg_lock_ff && wr_dcfg && !i_special_mode |=> $stable(dcfg_ff))
		else $error("delay register rewritten in normal mode");
	a_port_read: assert property (i_rd && i_addr == OFS_PORT_DATA
		|=> o_rdata[PORT_W-1:0] == $past(pdata_rd))
		else $error("port data read wrong");
	a_link_pins: assert property (link_on && !wr_pctl |=> o_pin_oe[PIN_RX] == 1'b0 && o_pin_oe[PIN_TX] == 1'b1)
		else $error("link pins not owned by controller");

endmodule

// ===== sim/vlhi_xcvr_model.sv
// Transceiver and pad model: drives pin levels seen by the block
`timescale 1ns/1ps
module vlhi_xcvr_model (
	input  wire logic [6:0] i_out,
	input  wire logic [6:0] i_oe,
	input  wire logic [6:0] i_ext,
	output logic      [6:0] o_pin
);
	// pin level
	// Driven pads show the block's value, others the far side's level
	assign o_pin = (i_out & i_oe) | (i_ext & ~i_oe);
endmodule

// ===== sim/vpw_link_host_interface_tb_top.sv
// Testbench: register-port tests of the link host interface block
`timescale 1ns/1ps
module vpw_link_host_interface_tb_top;
	import vlhi_pkg::*;
	logic i_clock, i_resetn, i_wr, i_rd, i_special_mode;
	logic [2:0] i_addr;
	logic [7:0] i_wdata, o_rdata, rdv;
	vlhi_evt_t i_evt, ev;
	logic [6:0] pin_in, o_pin_out, o_pin_oe, ext;
	logic o_pullup_en, o_reduced_drive, o_rx_level, o_onchip_sel;
	logic [11:0] o_delay_cycles;
	int fail_count, checks;
	logic [7:0] pri [5] = '{8'h20, 8'h18, 8'h14, 8'h04, 8'h00};
	vlhi_core #(.BIT_CYCLES(4), .PORT_W(7)) dut_u (.i_clock(i_clock), .i_resetn(i_resetn),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_special_mode(i_special_mode), .i_evt(i_evt), .i_pin_in(pin_in), .o_pin_out(o_pin_out),
		.o_pin_oe(o_pin_oe), .o_pullup_en(o_pullup_en), .o_reduced_drive(o_reduced_drive),
		.o_rx_level(o_rx_level), .o_delay_cycles(o_delay_cycles), .o_onchip_sel(o_onchip_sel));
	vlhi_xcvr_model pad_u (.i_out(o_pin_out), .i_oe(o_pin_oe), .i_ext(ext), .o_pin(pin_in));
	// ------------------------------------------------------------
	// Bus tasks and checks
	// ------------------------------------------------------------
	task automatic chk(input logic [11:0] g, input logic [11:0] e);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_clock);
		i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a);
		@(posedge i_clock);
		i_rd <= 1'b1; i_addr <= a;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1 rdv = o_rdata;
	endtask
	task automatic pulse(input vlhi_evt_t e);
		@(posedge i_clock);
		i_evt <= e;
		@(posedge i_clock);
		i_evt <= '0;
	endtask
	// Poll the vector with a bound; a miss ends the run
	task automatic wait_vec(input logic [7:0] e, input int n);
		for (int k = 0; k < n; k++) begin
			rd(OFS_VECTOR);
			if (rdv === e) return;
		end
		chk(rdv, e);
		close_out();
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{i_resetn, i_wr, i_rd, i_special_mode, i_addr, i_wdata, i_evt, ev} = '0;
		ext = 7'h55;
		fail_count = 0; checks = 0;
		repeat (3) @(posedge i_clock);
		i_resetn <= 1'b1;
		for (int a = 2; a < 8; a++) begin
			rd(a[2:0]);
			chk(rdv, (a == 4) ? 8'h55 : 8'h00);
		end
		chk(o_pin_oe, 7'h00);
		chk(o_delay_cycles, 12'h384);
		$display("test reset done");
		// Outputs by direction, inputs by pin level
		wr(OFS_PORT_DIR, 8'h0c);
		wr(OFS_PORT_DATA, 8'h08);
		rd(OFS_PORT_DATA);
		chk(rdv, 8'h59);
		chk(o_pin_oe, 7'h0c);
		chk(o_pin_out & 7'h0c, 7'h08);
		wr(OFS_PORT_CTL, 8'h07);
		// Pin registers follow the control register one edge later
		repeat (2) @(posedge i_clock);
		chk({o_pullup_en, o_reduced_drive}, 2'b11);
		chk(o_pin_oe, 7'h0e);
		// Port latch must not reach the link-driven transmit pin
		wr(OFS_PORT_DIR, 8'h0e);
		wr(OFS_PORT_DATA, 8'h0a);
		repeat (2) @(posedge i_clock);
		chk(o_pin_oe, 7'h0e);
		chk(o_pin_out & 7'h0e, 7'h08);
		$display("test port done");
		// Delay config keeps onchip select zero
		wr(OFS_DELAY_CFG, 8'h4f);
		wr(OFS_DELAY_CFG, 8'h00);
		rd(OFS_DELAY_CFG);
		chk(rdv, 8'h4f);
		chk({o_onchip_sel, o_rx_level}, 2'b01);
		i_special_mode <= 1'b1;
		for (int k = 0; k < 16; k++) begin
			wr(OFS_DELAY_CFG, 8'(k));
			repeat (2) @(posedge i_clock);
			chk(o_delay_cycles, 12'((9 + k) * 100));
		end
		@(posedge i_clock);
		chk(o_rx_level, 1'b0);
		ext[0] <= 1'b0;
		repeat (3) @(posedge i_clock);
		chk(o_rx_level, 1'b1);
		$display("test delay done");
		// Priority order and read-to-clear
		ev = '0; ev.wakeup = 1; ev.crc_err = 1; ev.arb_loss = 1; ev.eof = 1;
		pulse(ev);
		for (int k = 0; k < 5; k++) begin
			rd(OFS_VECTOR);
			chk(rdv, pri[k]);
		end
		// Invalid symbol blocks reception until end-of-frame
		ev = '0; ev.sym_invalid = 1; pulse(ev);
		rd(OFS_VECTOR); chk(rdv, 8'h1c);
		ev = '0; ev.byte_valid = 1; ev.byte_data = 8'h11; pulse(ev);
		rd(OFS_VECTOR); chk(rdv, 8'h00);
		ev = '0; ev.eof = 1; pulse(ev);
		rd(OFS_VECTOR); chk(rdv, 8'h04);
		ev = '0; ev.byte_valid = 1; ev.byte_data = 8'h11; pulse(ev);
		ev.byte_data = 8'ha5; pulse(ev);
		rd(OFS_VECTOR); chk(rdv, 8'h0c);
		rd(OFS_VECTOR); chk(rdv, 8'h0c);
		rd(OFS_DATA); chk(rdv, 8'ha5);
		rd(OFS_VECTOR); chk(rdv, 8'h00);
		ev.byte_ifr = 1; pulse(ev);
		rd(OFS_VECTOR); chk(rdv, 8'h08);
		rd(OFS_DATA);
		rd(OFS_VECTOR); chk(rdv, 8'h00);
		// Loopback disconnects bus events
		for (int k = 1; k < 3; k++) begin
			wr(OFS_CTL_TWO, 8'(k));
			ev = '0; ev.wakeup = 1; pulse(ev);
			chk(o_rx_level, 1'b0);
			rd(OFS_VECTOR); chk(rdv, 8'h00);
		end
		wr(OFS_CTL_TWO, 8'h00);
		$display("test vector done");
		// Double-buffered transmit, end-of-data, then underrun
		wr(OFS_DATA, 8'hc3);
		// First bit of the byte is a one on the transmit pin
		repeat (3) @(posedge i_clock);
		chk(o_pin_out[PIN_TX], 1'b1);
		wait_vec(8'h10, 20);
		rd(OFS_VECTOR); chk(rdv, 8'h10);
		wr(OFS_DATA, 8'h3c);
		rd(OFS_VECTOR); chk(rdv, 8'h00);
		wait_vec(8'h10, 40);
		wr(OFS_CTL_TWO, 8'h04);
		rd(OFS_VECTOR); chk(rdv, 8'h00);
		repeat (60) @(posedge i_clock);
		wr(OFS_DATA, 8'h81);
		wait_vec(8'h10, 20);
		wait_vec(8'h1c, 60);
		$display("test transmit done");
		close_out();
	end
endmodule
